// >>> hw/iac_top.sv
/*
 holds the interrupt accept block: pending latches, priority, mask check,
 acceptance indicator pin and transfer controller routing.
 assumes all inputs synchronous to ref_clk; srst is the power-on reset.
*/
// Functional notes
// - pick the highest programmed level among asserted requests, ignore lower ones
// - ties in level resolved by fixed order, lower vector number wins
// - accept and signal the cpu only when level exceeds the cpu mask level
// - on acceptance drive the acceptance indicator pin low
// - level or peripheral source: pin returns high once cpu updated its mask
// - edge source: pin returns high when cpu starts exception processing
// - higher priority accepted meanwhile keeps the pin low
// - edge requests stay pending until accepted, even when losing arbitration
// - software may cancel a pending external pin request via the status register
// - power-on or manual reset clears all edge pending requests
// - transfer check takes one state if capable, external always one
// - arbitration and mask compare take two states, external pins three
// - with transfer enable set, the request goes to the transfer controller
// - transfer end clears the enable only when select set or count zero
// - select set: each transfer clears enable and raises a cpu request
// - select clear, count not zero: each transfer clears the source flag, no cpu request
// - select clear at zero count: enable cleared, cpu request raised
// - each source has a four-bit priority, reset to level zero
`timescale 1ns/1ps
`include "iac_regs.svh"

module iac_top #(
  parameter int          N        = 8,
  parameter int          IW       = 3,
  parameter logic [N-1:0] EXT_MASK = 8'h0F,
  parameter logic [N-1:0] DTC_CAP  = 8'hFF
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    manual_rst,
  input  wire logic [N-1:0]            src_req,
  input  wire logic [N-1:0]            src_edge_mode,
  input  wire logic                    prio_wr_en,
  input  wire logic [IW-1:0]           prio_wr_idx,
  input  wire logic [3:0]              prio_wr_data,
  input  wire logic [N-1:0]            ext_status_clr,
  input  wire logic [3:0]              cpu_mask_level,
  input  wire logic                    cpu_exc_start,
  input  wire logic                    cpu_mask_updated,
  input  wire logic [N-1:0]            te_set,
  input  wire logic [N-1:0]            cpu_int_select_bit,
  input  wire logic                    xfer_done,
  input  wire logic [IW-1:0]           xfer_src,
  input  wire logic                    xfer_count_zero,
  output logic                         cpu_irq,
  output iac_pkg::iac_lvl_t            cpu_irq_level,
  output logic [IW-1:0]                cpu_irq_src,
  output logic                         accept_indicator_pin,
  output logic [N-1:0]                 transfer_enable_bit,
  output logic [N-1:0]                 dtc_req,
  output logic [N-1:0]                 src_flag_clr
);

  iac_pkg::iac_lvl_t            source_priority_regs [N];
  logic [4*N-1:0]               lvl_flat;
  logic [N-1:0]                 src_req_d;
  logic [N-1:0]                 pend;
  logic [N-1:0]                 pend_clr;
  logic [N-1:0]                 src_act;
  logic [N-1:0]                 cpu_side_req;
  logic [N-1:0]                 elig;
  logic [`IAC_AGE_W-1:0]        age [N];
  logic                         win_v;
  iac_pkg::iac_lvl_t            win_l;
  logic [IW-1:0]                win_i;
  logic                         next_acc;
  logic                         higher;
  iac_pkg::iac_acc_e            state;
  iac_pkg::iac_acc_e            next_state;
  iac_pkg::iac_lvl_t            hold_level;
  logic [IW-1:0]                hold_src;
  logic                         hold_edge;

  // states needed before a source may win
  function automatic logic [`IAC_AGE_W-1:0] need_of(input int i);
    if (EXT_MASK[i]) begin
      return `IAC_JUDGE_DTC + `IAC_ARB_EXT;
    end
    return (DTC_CAP[i] ? `IAC_JUDGE_DTC : `IAC_JUDGE_NONE) + `IAC_ARB_PER;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        source_priority_regs[i] <= `IAC_PRIO_RST;
      end
    end else if (prio_wr_en) begin
      source_priority_regs[prio_wr_idx] <= prio_wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      src_req_d <= '0;
    end else begin
      src_req_d <= src_req;
    end
  end

  assign pend_clr = (ext_status_clr & EXT_MASK) | src_flag_clr |
                    ((cpu_exc_start && state == iac_pkg::IAC_ACCEPTED && hold_edge) ?
                     (N'(1) << hold_src) : '0);

  always_ff @(posedge ref_clk) begin
    if (srst || manual_rst) begin
      pend <= '0;
    end else begin
      pend <= ((pend & ~pend_clr) | (src_req & ~src_req_d)) & src_edge_mode;
    end
  end

  assign src_act = (pend & src_edge_mode) | (src_req & ~src_edge_mode);

  generate
    for (genvar g = 0; g < N; g++) begin : g_src
      assign lvl_flat[4*g +: 4] = source_priority_regs[g];
      assign elig[g] = cpu_side_req[g] && (age[g] >= need_of(g) - 3'h1);
      always_ff @(posedge ref_clk) begin
        if (srst || !cpu_side_req[g]) begin
          age[g] <= '0;
        end else if (age[g] != `IAC_AGE_MAX) begin
          age[g] <= age[g] + 3'h1;
        end
      end
    end
  endgenerate

  iac_route #(
    .N  (N),
    .IW (IW)
  ) u_route (
    .ref_clk             (ref_clk),
    .srst                (srst),
    .src_act             (src_act),
    .te_set              (te_set),
    .cpu_int_select_bit  (cpu_int_select_bit),
    .xfer_done           (xfer_done),
    .xfer_src            (xfer_src),
    .xfer_count_zero     (xfer_count_zero),
    .transfer_enable_bit (transfer_enable_bit),
    .dtc_req             (dtc_req),
    .src_flag_clr        (src_flag_clr),
    .cpu_side_req        (cpu_side_req)
  );

  iac_arbiter #(
    .N  (N),
    .IW (IW)
  ) u_arb (
    .req   (elig),
    .lvl   (lvl_flat),
    .win_v (win_v),
    .win_l (win_l),
    .win_i (win_i)
  );

  assign next_acc = win_v && (win_l > cpu_mask_level);
  assign higher   = next_acc && (win_l > hold_level);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpu_irq       <= 1'b0;
      cpu_irq_level <= `IAC_PRIO_RST;
      cpu_irq_src   <= '0;
    end else begin
      cpu_irq       <= next_acc;
      cpu_irq_level <= win_l;
      cpu_irq_src   <= win_i;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      iac_pkg::IAC_IDLE: begin
        if (next_acc) begin
          next_state = iac_pkg::IAC_ACCEPTED;
        end
      end
      iac_pkg::IAC_ACCEPTED: begin
        if (cpu_exc_start && !higher) begin
          next_state = hold_edge ? iac_pkg::IAC_IDLE : iac_pkg::IAC_TAKEN;
        end
      end
      iac_pkg::IAC_TAKEN: begin
        if (higher) begin
          next_state = iac_pkg::IAC_ACCEPTED;
        end else if (cpu_mask_updated) begin
          next_state = iac_pkg::IAC_IDLE;
        end
      end
      default: begin
        next_state = iac_pkg::IAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= iac_pkg::IAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_level <= `IAC_PRIO_RST;
      hold_src   <= '0;
      hold_edge  <= 1'b0;
    end else if (next_acc && (state == iac_pkg::IAC_IDLE || higher)) begin
      hold_level <= win_l;
      hold_src   <= win_i;
      hold_edge  <= src_edge_mode[win_i];
    end else if (next_state == iac_pkg::IAC_IDLE) begin
      hold_level <= `IAC_PRIO_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accept_indicator_pin <= `IAC_PIN_IDLE;
    end else begin
      accept_indicator_pin <= (next_state == iac_pkg::IAC_IDLE);
    end
  end

  sequence s_taken_level;
    state == iac_pkg::IAC_TAKEN && cpu_mask_updated && !higher;
  endsequence

  sequence s_edge_start;
    state == iac_pkg::IAC_ACCEPTED && hold_edge && cpu_exc_start && !higher;
  endsequence

  AST_MASK_GATE: assert property (@(posedge ref_clk) disable iff (srst)
    cpu_irq |-> cpu_irq_level > $past(cpu_mask_level))
    else $error("request at or below mask reached cpu");

  AST_PIN_LOW: assert property (@(posedge ref_clk) disable iff (srst)
    next_acc && state == iac_pkg::IAC_IDLE |=> !accept_indicator_pin && cpu_irq)
    else $error("pin not low on acceptance");

  AST_LEVEL_REL: assert property (@(posedge ref_clk) disable iff (srst)
    s_taken_level |=> accept_indicator_pin)
    else $error("pin not released after mask update");

  AST_EDGE_REL: assert property (@(posedge ref_clk) disable iff (srst)
    s_edge_start |=> accept_indicator_pin ##1 !pend[$past(hold_src, 2)])
    else $error("edge acceptance not released");

  AST_HOLD_LOW: assert property (@(posedge ref_clk) disable iff (srst)
    state != iac_pkg::IAC_IDLE && higher |=> !accept_indicator_pin)
    else $error("pin released under higher acceptance");

  AST_PEND_KEEP: assert property (@(posedge ref_clk) disable iff (srst || manual_rst)
    1'b1 |=> ((($past(pend) & ~$past(pend_clr)) & ~pend) == '0))
    else $error("pending edge request lost");

  AST_MANUAL_CLR: assert property (@(posedge ref_clk) disable iff (srst)
    manual_rst |=> pend == '0)
    else $error("pending not cleared by manual reset");

  AST_LATENCY: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(cpu_irq) |-> $past(age[win_i]) >= need_of(int'(cpu_irq_src)) - 3'h1)
    else $error("request accepted too early");

  AST_WIN_TOP: assert property (@(posedge ref_clk) disable iff (srst)
    win_v |-> (elig[0] == 1'b0 || source_priority_regs[0] <= win_l))
    else $error("lower level chosen over source zero");

  AST_REST_HIGH: assert property (@(posedge ref_clk) disable iff (srst)
    state == iac_pkg::IAC_IDLE |-> accept_indicator_pin)
    else $error("pin low while idle");

  AST_CANCEL: assert property (@(posedge ref_clk) disable iff (srst || manual_rst)
    (ext_status_clr & EXT_MASK) != '0 |=>
      (pend & $past(ext_status_clr & EXT_MASK & ~(src_req & ~src_req_d))) == '0)
    else $error("cancelled request still pending");

  AST_PRIO_RST: assert property (@(posedge ref_clk) disable iff (srst)
    $past(srst) |-> lvl_flat == '0)
    else $error("priority not cleared by reset");

  AST_TE_WITHHOLD: assert property (@(posedge ref_clk) disable iff (srst)
    cpu_irq |-> !$past(transfer_enable_bit[win_i]))
    else $error("cpu request while transfer enable set");

endmodule

// >>> hw/iac_regs.svh
/*
 holds the timing counts, widths and reset values of the interrupt accept block.
 assumes it is included by bare name inside the design files.
*/
`ifndef IAC_REGS_SVH
`define IAC_REGS_SVH

`define IAC_LVL_W       4
`define IAC_AGE_W       3
`define IAC_AGE_MAX     3'h7
`define IAC_PRIO_RST    4'h0
`define IAC_JUDGE_DTC   3'h1
`define IAC_JUDGE_NONE  3'h0
`define IAC_ARB_EXT     3'h3
`define IAC_ARB_PER     3'h2
`define IAC_PIN_IDLE    1'b1

`endif

// >>> hw/iac_pkg.sv
/*
 holds the types shared by the interrupt accept block.
 assumes the constants header is compiled with it.
*/
package iac_pkg;

  typedef logic [3:0] iac_lvl_t;

  // gray coded along idle, accepted, taken
  typedef enum logic [1:0] {
    IAC_IDLE     = 2'b00,
    IAC_ACCEPTED = 2'b01,
    IAC_TAKEN    = 2'b11
  } iac_acc_e;

endpackage

// >>> hw/iac_arbiter.sv
/*
 holds the combinational priority pick among eligible sources.
 assumes levels arrive flattened, source 0 lowest vector number.
*/
`timescale 1ns/1ps
`include "iac_regs.svh"

module iac_arbiter #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  input  wire logic [N-1:0]            req,
  input  wire logic [4*N-1:0]          lvl,
  output logic                         win_v,
  output iac_pkg::iac_lvl_t            win_l,
  output logic [IW-1:0]                win_i
);

  // highest level wins, lower index wins ties
  always_comb begin
    win_v = 1'b0;
    win_l = `IAC_PRIO_RST;
    win_i = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!win_v || lvl[4*i +: 4] >= win_l)) begin
        win_v = 1'b1;
        win_l = lvl[4*i +: 4];
        win_i = IW'(i);
      end
    end
  end

endmodule

// >>> hw/iac_route.sv
/*
 holds the per-source routing between transfer controller and cpu.
 assumes xfer_done is a one-cycle pulse naming the source in xfer_src.
*/
`timescale 1ns/1ps
`include "iac_regs.svh"

module iac_route #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic [N-1:0]            src_act,
  input  wire logic [N-1:0]            te_set,
  input  wire logic [N-1:0]            cpu_int_select_bit,
  input  wire logic                    xfer_done,
  input  wire logic [IW-1:0]           xfer_src,
  input  wire logic                    xfer_count_zero,
  output logic [N-1:0]                 transfer_enable_bit,
  output logic [N-1:0]                 dtc_req,
  output logic [N-1:0]                 src_flag_clr,
  output logic [N-1:0]                 cpu_side_req
);

  logic [N-1:0] hit;
  logic         enable_clear_condition;

  assign hit = N'(1) << xfer_src;
  assign enable_clear_condition = cpu_int_select_bit[xfer_src] | xfer_count_zero;
  assign cpu_side_req = src_act & ~transfer_enable_bit;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      transfer_enable_bit <= '0;
    end else if (xfer_done && enable_clear_condition) begin
      transfer_enable_bit <= (transfer_enable_bit & ~hit) | te_set;
    end else begin
      transfer_enable_bit <= transfer_enable_bit | te_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      src_flag_clr <= '0;
    end else begin
      src_flag_clr <= (xfer_done && !enable_clear_condition) ? hit : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dtc_req <= '0;
    end else begin
      dtc_req <= src_act & transfer_enable_bit;
    end
  end

  AST_SEL_CLEARS: assert property (@(posedge ref_clk) disable iff (srst)
    (xfer_done && cpu_int_select_bit[xfer_src] && !te_set[xfer_src])
      |=> !transfer_enable_bit[$past(xfer_src)] && src_flag_clr == '0)
    else $error("enable not cleared in select mode");

  AST_KEEP_ENABLE: assert property (@(posedge ref_clk) disable iff (srst)
    (xfer_done && !enable_clear_condition && transfer_enable_bit[xfer_src])
      |=> transfer_enable_bit[$past(xfer_src)] && src_flag_clr[$past(xfer_src)])
    else $error("flag not cleared or enable lost");

  AST_ZERO_END: assert property (@(posedge ref_clk) disable iff (srst)
    (xfer_done && xfer_count_zero && !te_set[xfer_src])
      |=> !transfer_enable_bit[$past(xfer_src)])
    else $error("enable kept at zero count");

  AST_DTC_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
    (dtc_req & ~$past(transfer_enable_bit)) == '0)
    else $error("transfer request without enable");

endmodule

// >>> test/iac_cpu_model.sv
/*
 holds a behavioural cpu core that takes interrupt exceptions.
 assumes the request, level and pulses are synchronous to ref_clk.
*/
`timescale 1ns/1ps

module iac_cpu_model (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              cpu_irq,
  input  wire iac_pkg::iac_lvl_t cpu_irq_level,
  input  wire logic              mask_load,
  input  wire logic [3:0]        mask_val,
  input  int                     wait_cycles,
  output logic [3:0]             cpu_mask_level,
  output logic                   cpu_exc_start,
  output logic                   cpu_mask_updated
);
  logic [3:0] lvl;

  initial begin
    cpu_mask_level = 4'h0;
    cpu_exc_start = 1'b0;
    cpu_mask_updated = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (srst) begin
        cpu_mask_level <= 4'h0;
      end else if (mask_load) begin
        cpu_mask_level <= mask_val;
      end else if (cpu_irq === 1'b1) begin
        repeat (wait_cycles) @(posedge ref_clk);
        lvl = cpu_irq_level;
        cpu_exc_start <= 1'b1;
        @(posedge ref_clk);
        cpu_exc_start <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cpu_mask_level <= lvl;
        cpu_mask_updated <= 1'b1;
        @(posedge ref_clk);
        cpu_mask_updated <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
    end
  end
endmodule

// >>> test/tb_top.sv
/*
 holds the self-checking bench of the interrupt accept block.
 assumes the cpu model answers requests; the bench drives all other inputs.
*/
`timescale 1ns/1ps

module tb_top;
  typedef struct {
    int         src;
    logic [3:0] prio;
    logic [3:0] mask;
    int         w;
    logic       exp;
  } iac_row_s;

  logic              ref_clk, srst, manual_rst, prio_wr_en, xfer_done, xfer_count_zero;
  logic              mask_load, cpu_irq, accept_indicator_pin, cpu_exc_start, cpu_mask_updated;
  logic [7:0]        src_req, src_edge_mode, ext_status_clr, te_set, cpu_int_select_bit;
  logic [7:0]        transfer_enable_bit, dtc_req, src_flag_clr;
  logic [2:0]        prio_wr_idx, xfer_src, cpu_irq_src;
  logic [3:0]        prio_wr_data, cpu_mask_level, mask_val;
  iac_pkg::iac_lvl_t cpu_irq_level;
  int                wait_cycles, errors, num_checks, i, k, need;
  iac_row_s          rows [6];
  iac_row_s          r;

  iac_top iac_top_inst (
    .ref_clk, .srst, .manual_rst, .src_req, .src_edge_mode, .prio_wr_en, .prio_wr_idx,
    .prio_wr_data, .ext_status_clr, .cpu_mask_level, .cpu_exc_start, .cpu_mask_updated,
    .te_set, .cpu_int_select_bit, .xfer_done, .xfer_src, .xfer_count_zero, .cpu_irq,
    .cpu_irq_level, .cpu_irq_src, .accept_indicator_pin, .transfer_enable_bit, .dtc_req,
    .src_flag_clr
  );

  iac_cpu_model iac_cpu_model_inst (
    .ref_clk, .srst, .cpu_irq, .cpu_irq_level, .mask_load, .mask_val, .wait_cycles,
    .cpu_mask_level, .cpu_exc_start, .cpu_mask_updated
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // s: 0 exception start, 1 mask updated, 2 cpu request
  task automatic wt(input int s);
    int n;
    n = 0;
    while (n < 40 && (s == 0 ? cpu_exc_start : s == 1 ? cpu_mask_updated : cpu_irq) !== 1'b1) begin
      tick(1);
      n++;
    end
    chk("wait", 8'h01, 8'(n < 40));
  endtask

  task automatic prio(input int idx, input logic [3:0] v);
    prio_wr_en = 1'b1;
    prio_wr_idx = 3'(idx);
    prio_wr_data = v;
    tick(1);
    prio_wr_en = 1'b0;
  endtask

  task automatic setm(input logic [3:0] v);
    mask_val = v;
    mask_load = 1'b1;
    tick(5);
    mask_load = 1'b0;
    tick(1);
  endtask

  task automatic serve;
    wt(1);
    tick(1);
    chk("pin idle", 8'h01, 8'(accept_indicator_pin));
    src_req = 8'h00;
    setm(4'h0);
  endtask

  task automatic xfer(input logic c);
    xfer_done = 1'b1;
    xfer_src = 3'h5;
    xfer_count_zero = c;
    tick(1);
    xfer_done = 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    finish_test;
  end

  initial begin
    srst = 1'b1;
    manual_rst = 1'b0;
    src_req = 8'h00;
    src_edge_mode = 8'h0C;
    prio_wr_en = 1'b0;
    prio_wr_idx = 3'h0;
    prio_wr_data = 4'h0;
    ext_status_clr = 8'h00;
    te_set = 8'h00;
    cpu_int_select_bit = 8'h00;
    xfer_done = 1'b0;
    xfer_src = 3'h0;
    xfer_count_zero = 1'b0;
    mask_load = 1'b0;
    mask_val = 4'h0;
    wait_cycles = 3;
    errors = 0;
    num_checks = 0;
    rows = '{'{0, 4'h5, 4'h0, 0, 1'b1}, '{0, 4'h5, 4'h5, 3, 1'b0}, '{1, 4'h5, 4'h4, 3, 1'b1},
             '{5, 4'hF, 4'hE, 0, 1'b1}, '{7, 4'h1, 4'h0, 3, 1'b1}, '{6, 4'h9, 4'h9, 0, 1'b0}};
    tick(4);
    srst = 1'b0;
    tick(1);
    chk("pin reset", 8'h01, 8'(accept_indicator_pin));
    chk("irq reset", 8'h00, 8'(cpu_irq));
    chk("te reset", 8'h00, transfer_enable_bit);
    src_req = 8'h40;
    tick(6);
    chk("irq prio0", 8'h00, 8'(cpu_irq));
    src_req = 8'h00;
    for (i = 0; i < 6; i++) begin
      r = rows[i];
      wait_cycles = r.w;
      setm(r.mask);
      prio(r.src, r.prio);
      need = (r.src < 4) ? 4 : 3;
      src_req = 8'h01 << r.src;
      tick(need - 1);
      chk("irq early", 8'h00, 8'(cpu_irq));
      tick(1);
      chk("irq", 8'(r.exp), 8'(cpu_irq));
      if (r.exp) begin
        chk("level", 8'(r.prio), 8'(cpu_irq_level));
        chk("src", 8'(r.src), 8'(cpu_irq_src));
        chk("pin low", 8'h00, 8'(accept_indicator_pin));
        wt(1);
        chk("pin held", 8'h00, 8'(accept_indicator_pin));
        serve;
      end
      src_req = 8'h00;
      setm(4'h0);
    end
    wait_cycles = 3;
    for (k = 0; k < 2; k++) begin
      prio(0, k ? 4'h9 : 4'h7);
      prio(1, 4'h9);
      src_req = 8'h03;
      tick(4);
      chk("winner", k ? 8'h00 : 8'h01, 8'(cpu_irq_src));
      chk("win level", 8'h09, 8'(cpu_irq_level));
      serve;
    end
    prio(0, 4'h8);
    prio(2, 4'h3);
    src_req = 8'h05;
    tick(1);
    src_req = 8'h01;
    wt(2);
    chk("src first", 8'h00, 8'(cpu_irq_src));
    serve;
    wt(2);
    chk("src pend", 8'h02, 8'(cpu_irq_src));
    wt(0);
    chk("pin at exc", 8'h00, 8'(accept_indicator_pin));
    tick(1);
    chk("pin edge", 8'h01, 8'(accept_indicator_pin));
    serve;
    tick(8);
    chk("pend taken", 8'h00, 8'(cpu_irq));
    prio(3, 4'h6);
    for (k = 0; k < 2; k++) begin
      src_req = 8'h08;
      tick(1);
      src_req = 8'h00;
      manual_rst = (k == 0);
      ext_status_clr = k ? 8'h08 : 8'h00;
      tick(1);
      manual_rst = 1'b0;
      ext_status_clr = 8'h00;
      tick(8);
      chk("cancel", 8'h00, 8'(cpu_irq));
    end
    te_set = 8'h20;
    tick(1);
    te_set = 8'h00;
    chk("te set", 8'h01, 8'(transfer_enable_bit[5]));
    src_req = 8'h20;
    tick(6);
    chk("irq held", 8'h00, 8'(cpu_irq));
    chk("dtc req", 8'h01, 8'(dtc_req[5]));
    xfer(1'b0);
    chk("flag clr", 8'h20, src_flag_clr);
    chk("te kept", 8'h01, 8'(transfer_enable_bit[5]));
    tick(1);
    chk("flag pulse", 8'h00, src_flag_clr);
    xfer(1'b1);
    chk("te zero", 8'h00, 8'(transfer_enable_bit[5]));
    chk("no flag", 8'h00, src_flag_clr);
    wt(2);
    chk("end irq", 8'h05, 8'(cpu_irq_src));
    serve;
    cpu_int_select_bit = 8'h20;
    te_set = 8'h20;
    src_req = 8'h20;
    tick(1);
    te_set = 8'h00;
    tick(2);
    xfer(1'b0);
    chk("te sel", 8'h00, 8'(transfer_enable_bit[5]));
    chk("flag kept", 8'h00, src_flag_clr);
    wt(2);
    chk("sel irq", 8'h05, 8'(cpu_irq_src));
    serve;
    src_req = 8'h80;
    wt(2);
    chk("low level", 8'h01, 8'(cpu_irq_level));
    wt(0);
    src_req = 8'hC0;
    wt(1);
    tick(1);
    chk("pin kept", 8'h00, 8'(accept_indicator_pin));
    chk("new level", 8'h09, 8'(cpu_irq_level));
    serve;
    finish_test;
  end
endmodule
